// file: pocs_map.vh
// Constants for the pluggable optic control and status block.
// Included by the block's top-level design file; holds definitions only.
`ifndef POCS_MAP_VH
`define POCS_MAP_VH

// Two-wire device addresses (upper seven bits)
`define POCS_DEV_ID_PAGE    7'h50
`define POCS_DEV_ID_DIAG    7'h51

// Control/status byte and its fields
`define POCS_REG_CTRL       8'h6E
`define POCS_BIT_DIS_STATE  7
`define POCS_BIT_SOFT_DIS   6
`define POCS_BIT_TX_FAULT   2
`define POCS_BIT_RX_LOST    1
`define POCS_CTRL_RST       1'b0

// Live monitor bytes in the diagnostic page
`define POCS_LIVE_FIRST     8'h60
`define POCS_LIVE_LAST      8'h69
`define POCS_TEMP_MSB       8'h60
`define POCS_TEMP_LSB       8'h61
`define POCS_VCC_MSB        8'h62
`define POCS_VCC_LSB        8'h63
`define POCS_BIAS_MSB       8'h64
`define POCS_BIAS_LSB       8'h65
`define POCS_TXPWR_MSB      8'h66
`define POCS_TXPWR_LSB      8'h67
`define POCS_RXPWR_MSB      8'h68
`define POCS_RXPWR_LSB      8'h69

// Bit counting and pointer step on the serial link
`define POCS_BITS_BYTE      4'h8
`define POCS_CNT_ZERO       4'h0
`define POCS_CNT_ONE        4'h1
`define POCS_PTR_ONE        8'h01

// Synchroniser lanes and their reset levels
`define POCS_SYNC_W         5
`define POCS_SYNC_RST       5'h07
`define POCS_LN_SCL         0
`define POCS_LN_SDA         1
`define POCS_LN_DIS         2
`define POCS_LN_FAULT       3
`define POCS_LN_LOST        4

`endif

// file: pocs_sync.v
// Two flip-flop synchroniser for one asynchronous level.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module pocs_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Level in and out
  input  wire d_i,
  output wire q_o
);

  reg meta_r;
  reg stable_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r   <= RST_VAL;
      stable_r <= RST_VAL;
    end else begin
      meta_r   <= d_i;
      stable_r <= meta_r;
    end
  end

  assign q_o = stable_r;

endmodule

`default_nettype wire

// file: pocs_top.v
// Control/status logic of a pluggable optic: shut-off, fault latch,
// signal-loss mirror and a two-wire slave with two 256-byte pages.
// Assumes pins are asynchronous; monitor words come from logic on REF_CLK_I.
`timescale 1ns/1ps
`default_nettype none
`include "pocs_map.vh"

module pocs_top (
  // Clock and reset
  input  wire        REF_CLK_I,
  input  wire        SYS_RST_I,
  // Host control pins
  input  wire        TX_DISABLE_I,
  output reg         TX_FAULT_O,
  output reg         TX_FAULT_OE_O,
  output reg         RX_SIGNAL_LOST_O,
  // Optical front end
  input  wire        TX_FAULT_DET_I,
  input  wire        RX_SIGNAL_LOST_DET_I,
  output reg         TX_LASER_EN_O,
  // Monitor words
  input  wire [15:0] TEMP_I,
  input  wire [15:0] VCC_I,
  input  wire [15:0] TX_BIAS_I,
  input  wire [15:0] TX_POWER_I,
  input  wire [15:0] RX_POWER_I,
  // Two-wire serial pins
  input  wire        SCL_I,
  input  wire        SDA_I,
  output reg         SDA_O,
  output reg         SDA_OE_O
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_DEV  = 9'h002;
  localparam [8:0] ST_ADEV = 9'h004;
  localparam [8:0] ST_WA   = 9'h008;
  localparam [8:0] ST_AWA  = 9'h010;
  localparam [8:0] ST_WR   = 9'h020;
  localparam [8:0] ST_AWR  = 9'h040;
  localparam [8:0] ST_RD   = 9'h080;
  localparam [8:0] ST_MACK = 9'h100;

  wire [`POCS_SYNC_W-1:0] raw_in;
  wire [`POCS_SYNC_W-1:0] sync_in;
  // Reset levels must be constant to serve as parameter overrides
  localparam [`POCS_SYNC_W-1:0] SYNC_RST = `POCS_SYNC_RST;

  assign raw_in = {RX_SIGNAL_LOST_DET_I, TX_FAULT_DET_I, TX_DISABLE_I, SDA_I, SCL_I};

  genvar g;
  generate
    for (g = 0; g < `POCS_SYNC_W; g = g + 1) begin : g_sync
      pocs_sync #(
        .RST_VAL (SYNC_RST[g])
      ) u_sync (
        .clk_i (REF_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (raw_in[g]),
        .q_o   (sync_in[g])
      );
    end
  endgenerate

  wire scl_s   = sync_in[`POCS_LN_SCL];
  wire sda_s   = sync_in[`POCS_LN_SDA];
  wire dis_s   = sync_in[`POCS_LN_DIS];
  wire fault_s = sync_in[`POCS_LN_FAULT];
  wire lost_s  = sync_in[`POCS_LN_LOST];

  reg        scl_d_r;
  reg        sda_d_r;
  reg        dis_d_r;
  reg        fault_r;
  reg        soft_dis_r;
  reg [8:0]  state_r;
  reg [3:0]  cnt_r;
  reg [7:0]  shift_r;
  reg [7:0]  ptr_r;
  reg        page_r;
  reg        ack_r;
  reg [79:0] live_r;

  reg [7:0]  id_mem   [0:255];
  reg [7:0]  diag_mem [0:255];

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire dis_rise = dis_s & ~dis_d_r;
  wire dev_hit  = (shift_r[7:1] == `POCS_DEV_ID_PAGE) | (shift_r[7:1] == `POCS_DEV_ID_DIAG);

  // Live bytes are read-only and come from the snapshot
  function is_live;
    input [7:0] a;
    begin
      is_live = (a >= `POCS_LIVE_FIRST) && (a <= `POCS_LIVE_LAST);
    end
  endfunction

  function [7:0] live_byte;
    input [7:0]  a;
    input [79:0] v;
    begin
      case (a)
        `POCS_TEMP_MSB:  live_byte = v[79:72];
        `POCS_TEMP_LSB:  live_byte = v[71:64];
        `POCS_VCC_MSB:   live_byte = v[63:56];
        `POCS_VCC_LSB:   live_byte = v[55:48];
        `POCS_BIAS_MSB:  live_byte = v[47:40];
        `POCS_BIAS_LSB:  live_byte = v[39:32];
        `POCS_TXPWR_MSB: live_byte = v[31:24];
        `POCS_TXPWR_LSB: live_byte = v[23:16];
        `POCS_RXPWR_MSB: live_byte = v[15:8];
        default:         live_byte = v[7:0];
      endcase
    end
  endfunction

  // Byte 110 is composed from live conditions on every read
  wire [7:0] ctrl_byte;
  assign ctrl_byte[`POCS_BIT_DIS_STATE] = dis_s;
  assign ctrl_byte[`POCS_BIT_SOFT_DIS]  = soft_dis_r;
  assign ctrl_byte[5:3]                 = 3'h0;
  assign ctrl_byte[`POCS_BIT_TX_FAULT]  = fault_r;
  assign ctrl_byte[`POCS_BIT_RX_LOST]   = lost_s;
  assign ctrl_byte[0]                   = 1'b0;

  reg [7:0] rd_byte;
  always @* begin
    if (!page_r) begin
      rd_byte = id_mem[ptr_r];
    end else if (ptr_r == `POCS_REG_CTRL) begin
      rd_byte = ctrl_byte;
    end else if (is_live(ptr_r)) begin
      rd_byte = live_byte(ptr_r, live_r);
    end else begin
      rd_byte = diag_mem[ptr_r];
    end
  end

  wire wr_en = (state_r == ST_WR) && scl_fall && (cnt_r == `POCS_BITS_BYTE);

  // Memory pages hold no reset; software owns their contents
  always @(posedge REF_CLK_I) begin
    if (wr_en && !page_r) begin
      id_mem[ptr_r] <= shift_r;
    end
    if (wr_en && page_r && (ptr_r != `POCS_REG_CTRL) && !is_live(ptr_r)) begin
      diag_mem[ptr_r] <= shift_r;
    end
  end

  // Pin control, fault latch and software shut-off
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      scl_d_r          <= 1'b1;
      sda_d_r          <= 1'b1;
      dis_d_r          <= 1'b1;
      fault_r          <= 1'b0;
      soft_dis_r       <= `POCS_CTRL_RST;
      TX_LASER_EN_O    <= 1'b0;
      TX_FAULT_O       <= 1'b0;
      TX_FAULT_OE_O    <= 1'b1;
      RX_SIGNAL_LOST_O <= 1'b0;
      SDA_O            <= 1'b0;
    end else begin
      scl_d_r          <= scl_s;
      sda_d_r          <= sda_s;
      dis_d_r          <= dis_s;
      // New fault wins over a clear in the same cycle
      fault_r          <= fault_s | (fault_r & ~dis_rise);
      if (wr_en && page_r && (ptr_r == `POCS_REG_CTRL)) begin
        soft_dis_r     <= shift_r[`POCS_BIT_SOFT_DIS];
      end
      TX_LASER_EN_O    <= ~(dis_s | soft_dis_r | fault_r | fault_s);
      TX_FAULT_O       <= 1'b0;
      TX_FAULT_OE_O    <= ~(fault_r | fault_s);
      RX_SIGNAL_LOST_O <= lost_s;
      SDA_O            <= 1'b0;
    end
  end

  // Two-wire slave: sample on SCL rise, drive on SCL fall
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_r  <= ST_IDLE;
      cnt_r    <= `POCS_CNT_ZERO;
      shift_r  <= 8'h00;
      ptr_r    <= 8'h00;
      page_r   <= 1'b0;
      ack_r    <= 1'b0;
      live_r   <= 80'h0;
      SDA_OE_O <= 1'b0;
    end else if (start_ev) begin
      state_r  <= ST_DEV;
      cnt_r    <= `POCS_CNT_ZERO;
      SDA_OE_O <= 1'b0;
    end else if (stop_ev) begin
      state_r  <= ST_IDLE;
      SDA_OE_O <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          SDA_OE_O <= 1'b0;
        end
        ST_DEV, ST_WA, ST_WR: begin
          if (scl_rise && (cnt_r != `POCS_BITS_BYTE)) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r   <= cnt_r + `POCS_CNT_ONE;
          end else if (scl_fall && (cnt_r == `POCS_BITS_BYTE)) begin
            case (state_r)
              ST_DEV: begin
                if (dev_hit) begin
                  page_r   <= shift_r[1];
                  ack_r    <= shift_r[0];
                  live_r   <= {TEMP_I, VCC_I, TX_BIAS_I, TX_POWER_I, RX_POWER_I};
                  SDA_OE_O <= 1'b1;
                  state_r  <= ST_ADEV;
                end else begin
                  state_r  <= ST_IDLE;
                end
              end
              ST_WA: begin
                ptr_r    <= shift_r;
                SDA_OE_O <= 1'b1;
                state_r  <= ST_AWA;
              end
              default: begin
                ptr_r    <= ptr_r + `POCS_PTR_ONE;
                SDA_OE_O <= 1'b1;
                state_r  <= ST_AWR;
              end
            endcase
          end
        end
        ST_ADEV: begin
          if (scl_fall) begin
            cnt_r <= `POCS_CNT_ZERO;
            if (ack_r) begin
              shift_r  <= rd_byte;
              SDA_OE_O <= ~rd_byte[7];
              state_r  <= ST_RD;
            end else begin
              SDA_OE_O <= 1'b0;
              state_r  <= ST_WA;
            end
          end
        end
        ST_AWA, ST_AWR: begin
          if (scl_fall) begin
            cnt_r    <= `POCS_CNT_ZERO;
            SDA_OE_O <= 1'b0;
            state_r  <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + `POCS_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_r == `POCS_BITS_BYTE) begin
              ptr_r    <= ptr_r + `POCS_PTR_ONE;
              SDA_OE_O <= 1'b0;
              state_r  <= ST_MACK;
            end else begin
              shift_r  <= {shift_r[6:0], 1'b0};
              SDA_OE_O <= ~shift_r[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ack_r <= ~sda_s;
          end else if (scl_fall) begin
            cnt_r <= `POCS_CNT_ZERO;
            if (ack_r) begin
              shift_r  <= rd_byte;
              SDA_OE_O <= ~rd_byte[7];
              state_r  <= ST_RD;
            end else begin
              SDA_OE_O <= 1'b0;
              state_r  <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          SDA_OE_O <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: pocs_chk.sv
// Port assertions for the optic control/status block.
// Bound into pocs_top; one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pocs_chk (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Watched pins
  input wire logic TX_DISABLE_I,
  input wire logic TX_FAULT_DET_I,
  input wire logic RX_SIGNAL_LOST_DET_I,
  input wire logic TX_FAULT_O,
  input wire logic TX_FAULT_OE_O,
  input wire logic RX_SIGNAL_LOST_O,
  input wire logic TX_LASER_EN_O,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_dis_laser_off: assert property (TX_DISABLE_I [*4] |=> !TX_LASER_EN_O)
    else $error("laser on under shut-off");
  a_fault_kills: assert property (TX_FAULT_DET_I [*4] |=> !TX_LASER_EN_O && !TX_FAULT_OE_O)
    else $error("fault not taken");
  a_laser_no_fault: assert property (TX_LASER_EN_O |-> TX_FAULT_OE_O)
    else $error("laser on with fault");
  a_fault_held: assert property (!TX_DISABLE_I [*5] ##0 !TX_FAULT_OE_O |=> !TX_FAULT_OE_O)
    else $error("fault dropped");
  a_dis_clears: assert property ((!TX_DISABLE_I && !TX_FAULT_DET_I) [*4] ##1
    (TX_DISABLE_I && !TX_FAULT_DET_I) [*6] |-> TX_FAULT_OE_O)
    else $error("fault not cleared");
  a_los_high: assert property (RX_SIGNAL_LOST_DET_I [*4] |=> RX_SIGNAL_LOST_O)
    else $error("loss not shown");
  a_los_low: assert property (!RX_SIGNAL_LOST_DET_I [*4] |=> !RX_SIGNAL_LOST_O)
    else $error("loss stuck");
  a_open_drain: assert property (!TX_FAULT_O && !SDA_O)
    else $error("open-drain data high");
  a_sda_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("data moved with clock high");
  c_fault: cover property (!TX_FAULT_OE_O);
  c_ack: cover property ($rose(SDA_OE_O));
  c_laser: cover property (TX_LASER_EN_O ##1 !TX_LASER_EN_O);
  c_los: cover property ($rose(RX_SIGNAL_LOST_O));
endmodule
bind pocs_top pocs_chk u_chk (.REF_CLK_I, .SYS_RST_I, .TX_DISABLE_I, .TX_FAULT_DET_I, .RX_SIGNAL_LOST_DET_I,
  .TX_FAULT_O, .TX_FAULT_OE_O, .RX_SIGNAL_LOST_O, .TX_LASER_EN_O, .SCL_I, .SDA_O, .SDA_OE_O);
`default_nettype wire

// file: pocs_host.sv
// Host two-wire master model: start, stop, bits, bytes.
// Moves on falling clock edges; bench resolves the line.
`timescale 1ns/1ps
`default_nettype none
module pocs_host (
  // Clock
  input  wire logic clk_i,
  // Serial line
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  int hc = 16;
  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start;
    sda_low_o = 1'h0;
    wt(hc / 2);
    scl_o = 1'h1;
    wt(hc);
    sda_low_o = 1'h1;
    wt(hc);
    scl_o = 1'h0;
    wt(hc / 2);
  endtask
  task automatic stop;
    sda_low_o = 1'h1;
    wt(hc / 2);
    scl_o = 1'h1;
    wt(hc);
    sda_low_o = 1'h0;
    wt(hc);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = !b;
    wt(hc / 2);
    scl_o = 1'h1;
    wt(hc / 2);
    r = sda_i;
    wt(hc / 2);
    scl_o = 1'h0;
    wt(hc / 2);
  endtask
  task automatic byte_x(input logic [7:0] b, input logic ak, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
    bit_x(ak, k);
  endtask
endmodule
`default_nettype wire

// file: test_pocs_top.sv
// Bench for pocs_top; serial host model, pins driven here.
// Needs pocs_host and pocs_chk compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_pocs_top;
  logic        clk = 0;
  logic        rst = 1;
  logic        dis = 1; // Pin idles high
  logic        fdet = 0;
  logic        ldet = 0;
  logic        k;
  logic [95:0] mw = '0;
  logic [7:0]  rb [10];
  logic [7:0]  v, a, d;
  int          seed = 32'h6A7E;
  int          err_total = 0;
  int          comparisons = 0;
  wire         scl, hlow, oe, sda_o, f_o, f_oe, los, laser;
  wire         sda = !(hlow || oe);
  wire         fline = f_oe ? f_o : 1'h1; // Host pull-up
  pocs_top dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .TX_DISABLE_I(dis), .TX_FAULT_O(f_o), .TX_FAULT_OE_O(f_oe),
    .RX_SIGNAL_LOST_O(los), .TX_FAULT_DET_I(fdet), .RX_SIGNAL_LOST_DET_I(ldet), .TX_LASER_EN_O(laser),
    .TEMP_I(mw[79:64]), .VCC_I(mw[63:48]), .TX_BIAS_I(mw[47:32]), .TX_POWER_I(mw[31:16]),
    .RX_POWER_I(mw[15:0]), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(oe));
  pocs_host h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(hlow));
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected control/status byte from pin and bit states
  function automatic logic [7:0] ctrl_exp(input logic sd, sw, fl, ls);
    return {sd, sw, 3'h0, fl, ls, 1'h0};
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] dv, ad, dt);
    h.start;
    h.byte_x(dv, 1'h1, d, k);
    chk(k, 8'h0);
    h.byte_x(ad, 1'h1, d, k);
    h.byte_x(dt, 1'h1, d, k);
    chk(k, 8'h0);
    h.stop;
  endtask
  task automatic rd(input logic [7:0] dv, ad, input int n);
    h.start;
    h.byte_x(dv, 1'h1, d, k);
    h.byte_x(ad, 1'h1, d, k);
    h.start;
    h.byte_x(dv | 8'h01, 1'h1, d, k);
    chk(k, 8'h0);
    for (int i = 0; i < n; i++) h.byte_x(8'hFF, i == n - 1, rb[i], k);
    h.stop;
  endtask
  initial forever #2.5 clk = !clk;
  initial begin
    #250000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    h.wt(8);
    chk(laser, 8'h0);
    chk(fline, 8'h0);
    dis = 1'h0;
    h.wt(8);
    chk(laser, 8'h1);
    $display("pins done");
    mw = {$random(seed), $random(seed), $random(seed)};
    wr(8'hA2, 8'h6E, 8'hFF);
    chk(laser, 8'h0);
    ldet = 1'h1;
    rd(8'hA2, 8'h6E, 1);
    chk(los, 8'h1);
    chk(rb[0], ctrl_exp(1'h0, 1'h1, 1'h0, 1'h1));
    wr(8'hA2, 8'h6E, 8'h00);
    ldet = 1'h0;
    rd(8'hA2, 8'h6E, 1);
    chk(rb[0], ctrl_exp(1'h0, 1'h0, 1'h0, 1'h0));
    chk(laser, 8'h1);
    rd(8'hA2, 8'h60, 10);
    for (int i = 0; i < 10; i++) chk(rb[i], mw[79 - 8 * i -: 8]);
    $display("status done");
    for (int i = 0; i < 4; i++) begin
      mw = {$random(seed), $random(seed), $random(seed)};
      a = (i == 0) ? 8'hFF : 8'h80 | 8'($random(seed));
      v = 8'($random(seed));
      wr(8'hA0, a, v);
      wr(8'hA2, a, ~v);
      rd(8'hA0, a, 1);
      chk(rb[0], v);
      rd(8'hA2, a, 1);
      chk(rb[0], ~v);
      rd(8'hA2, 8'h60 + 8'(2 * i), 4);
      for (int j = 0; j < 4; j++) chk(rb[j], mw[79 - 16 * i - 8 * j -: 8]);
    end
    h.start;
    h.byte_x(8'hA4, 1'h1, d, k);
    h.stop;
    chk(k, 8'h1);
    $display("memory done");
    fdet = 1'h1;
    h.wt(6);
    chk(fline, 8'h1);
    chk(laser, 8'h0);
    fdet = 1'h0;
    rd(8'hA2, 8'h6E, 1);
    chk(rb[0], ctrl_exp(1'h0, 1'h0, 1'h1, 1'h0));
    chk(fline, 8'h1);
    dis = 1'h1;
    h.wt(8);
    chk(fline, 8'h0);
    rd(8'hA2, 8'h6E, 1);
    chk(rb[0], ctrl_exp(1'h1, 1'h0, 1'h0, 1'h0));
    dis = 1'h0;
    fdet = 1'h1;
    h.wt(6);
    chk(fline, 8'h1);
    fdet = 1'h0;
    rst = 1'h1;
    h.wt(4);
    rst = 1'h0;
    h.wt(8);
    chk(fline, 8'h0);
    chk(laser, 8'h1);
    $display("fault done");
    report_and_stop;
  end
endmodule
`default_nettype wire
